/* design/ivl_vector_lookup.v */
/*
  Interrupt vector lookup. On an acknowledged interrupt it forms the address
  of the four-byte vector (fixed table at top of memory, or relocatable table
  at the vector base register), fetches the bytes little-endian over a byte
  read port and hands the service routine start address to the sequencer.
  Assumes the sequencer, the vector base register and the memory port all
  run on clk_i; none of the inputs need synchronising.
*/
`include "ivl_regs.vh"

module ivl_vector_lookup #(
  parameter ADDR_W = 24
) (
  // Clock and reset
  input  wire              clk_i,
  input  wire              rst_i,
  // Acknowledged request from the interrupt sequencer
  input  wire              ack_valid_i,
  input  wire [2:0]        ack_kind_i,
  input  wire [5:0]        ack_sel_i,
  input  wire [2:0]        ack_event_i,
  input  wire              i2c_mode_i,
  output wire              ack_ready_o,
  output reg               ack_reject_o,
  // Vector base register contents
  input  wire [ADDR_W-1:0] vector_base_register_i,
  // Byte read port toward memory
  output wire              mem_rd_o,
  output reg  [ADDR_W-1:0] mem_addr_o,
  input  wire              mem_rdy_i,
  input  wire [7:0]        mem_data_i,
  // Result toward the sequencer
  output wire              handler_valid_o,
  output reg  [31:0]       handler_addr_o,
  output reg  [ADDR_W-1:0] vector_addr_o
);

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_FETCH = 3'b010;
  localparam [2:0] ST_DONE  = 3'b100;

  reg  [2:0]        state;
  reg  [1:0]        byte_cnt;
  reg               brk_check;
  reg  [ADDR_W-1:0] base_q;

  reg  [5:0]        next_num;
  reg               next_fixed;
  reg  [ADDR_W-1:0] next_fixed_addr;
  reg               next_bad;
  reg  [5:0]        ser_base;
  wire [ADDR_W-1:0] reloc_addr;
  wire              is_break;

  // Base entry of each serial channel
  always @* begin
    case (ack_sel_i)
      6'h00:   ser_base = `IVL_NUM_SER0;
      6'h01:   ser_base = `IVL_NUM_SER1;
      6'h02:   ser_base = `IVL_NUM_SER2;
      6'h03:   ser_base = `IVL_NUM_SER3;
      default: ser_base = `IVL_NUM_SER4;
    endcase
  end

  // Source to entry decode; only the INT instruction reaches entries 1 to 7
  always @* begin
    next_num        = `IVL_NUM_BREAK;
    next_fixed      = 1'b0;
    next_fixed_addr = `IVL_FIX_RESET;
    next_bad        = 1'b0;
    case (ack_kind_i)
      `IVL_KIND_FIXED: begin
        next_fixed = 1'b1;
        case (ack_sel_i[3:0])
          `IVL_SEL_UNDEF:      next_fixed_addr = `IVL_FIX_UNDEF;
          `IVL_SEL_OVERFLOW:   next_fixed_addr = `IVL_FIX_OVERFLOW;
          `IVL_SEL_BREAK:      next_fixed_addr = `IVL_FIX_BREAK;
          `IVL_SEL_ADDR_MATCH: next_fixed_addr = `IVL_FIX_ADDR_MATCH;
          `IVL_SEL_WATCHDOG,
          `IVL_SEL_OSC_STOP,
          `IVL_SEL_LOW_VOLT:   next_fixed_addr = `IVL_FIX_WATCHDOG;
          `IVL_SEL_NMI:        next_fixed_addr = `IVL_FIX_NMI;
          `IVL_SEL_RESET:      next_fixed_addr = `IVL_FIX_RESET;
          default:             next_bad = 1'b1;
        endcase
        if (ack_sel_i[5:4] != 2'h0) begin
          next_bad = 1'b1;
        end
      end
      `IVL_KIND_SOFT: begin
        next_num = ack_sel_i;
      end
      `IVL_KIND_DMA: begin
        next_num = `IVL_NUM_DMA + ack_sel_i;
        next_bad = (ack_sel_i >= `IVL_CNT_DMA);
      end
      `IVL_KIND_TMR_A: begin
        next_num = `IVL_NUM_TMR_A + ack_sel_i;
        next_bad = (ack_sel_i >= `IVL_CNT_TMR_A);
      end
      `IVL_KIND_TMR_B: begin
        if (ack_sel_i == `IVL_TMR_B5_SEL) begin
          next_num = `IVL_NUM_TMR_B5;
        end else begin
          next_num = `IVL_NUM_TMR_B + ack_sel_i;
        end
        next_bad = (ack_sel_i >= `IVL_CNT_TMR_B);
      end
      `IVL_KIND_EXT_PIN: begin
        next_num = `IVL_NUM_EXT_PIN0 - ack_sel_i;
        next_bad = (ack_sel_i >= `IVL_CNT_EXT_PIN);
      end
      `IVL_KIND_SERIAL: begin
        next_bad = (ack_sel_i >= `IVL_CNT_SERIAL);
        if (i2c_mode_i) begin
          case (ack_event_i)
            `IVL_EV_NACK:       next_num = ser_base;
            `IVL_EV_ACK,
            `IVL_EV_START_STOP: next_num = ser_base + 6'h01;
            default:            next_bad = 1'b1;
          endcase
        end else begin
          case (ack_event_i)
            `IVL_EV_TX: next_num = ser_base;
            `IVL_EV_RX: next_num = ser_base + 6'h01;
            default:    next_bad = 1'b1;
          endcase
        end
      end
      default: begin
        next_bad = 1'b1;
      end
    endcase
  end

  // Base plus four times the entry number; an odd base costs the CPU time only
  assign reloc_addr = vector_base_register_i + {{(ADDR_W-8){1'b0}}, next_num, `IVL_ENTRY_SHIFT};
  assign is_break   = (ack_kind_i == `IVL_KIND_FIXED) && (ack_sel_i == {2'h0, `IVL_SEL_BREAK});

  assign ack_ready_o     = state[0];
  assign mem_rd_o        = state[1];
  assign handler_valid_o = state[2];

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state          <= ST_IDLE;
      byte_cnt       <= 2'h0;
      brk_check      <= 1'b0;
      base_q         <= {ADDR_W{1'b0}};
      mem_addr_o     <= {ADDR_W{1'b0}};
      vector_addr_o  <= {ADDR_W{1'b0}};
      handler_addr_o <= 32'h00000000;
      ack_reject_o   <= 1'b0;
    end else begin
      ack_reject_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (ack_valid_i) begin
            if (next_bad) begin
              ack_reject_o <= 1'b1;
            end else begin
              state     <= ST_FETCH;
              byte_cnt  <= 2'h0;
              base_q    <= vector_base_register_i;
              brk_check <= is_break;
              if (next_fixed) begin
                mem_addr_o    <= next_fixed_addr;
                vector_addr_o <= next_fixed_addr;
              end else begin
                mem_addr_o    <= reloc_addr;
                vector_addr_o <= reloc_addr;
              end
            end
          end
        end
        ST_FETCH: begin
          if (mem_rdy_i) begin
            handler_addr_o[{byte_cnt, 3'h0} +: 8] <= mem_data_i;
            byte_cnt   <= byte_cnt + 2'h1;
            mem_addr_o <= mem_addr_o + {{(ADDR_W-1){1'b0}}, 1'b1};
            if (byte_cnt == `IVL_LAST_BYTE) begin
              if (brk_check && (mem_data_i == `IVL_BRK_REDIRECT)) begin
                brk_check     <= 1'b0;
                mem_addr_o    <= base_q;
                vector_addr_o <= base_q;
              end else begin
                state <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

/* design/ivl_regs.vh */
/*
  Constants for the interrupt vector lookup block: fixed vector addresses,
  relocatable entry numbers, request kinds, serial events and fetch limits.
  Assumes a 24-bit byte address space and a byte-wide vector fetch port.
*/
// Operation
// - Each vector is four bytes, handler address
// - Accepted request yields handler address from vector
// - Fixed vectors sit at top-of-memory constant addresses
// - Break vector top byte all-ones uses entry 0
// - Watchdog, oscillator stop, low voltage share slot
// - Relocatable table: 256 bytes, 64 entries at base
// - Entry 0 at offset 0 serves break instruction
// - DMA channels use entries 8 to 11
// - First-group timers 0-4 use entries 12-16
// - Serial channels 0,1 use entries 17-20
// - Second-group timers 0-4 use entries 21-25
// - External pins use 26-31, pin five first
// - Second-group timer five uses entry 32
// - Serial channels 2-4 use entries 33-38
// - Table offsets add to base register value
// - I2C mode: NACK transmit, ACK/start-stop receive entry
`ifndef IVL_REGS_VH
`define IVL_REGS_VH

// Fixed vector addresses, low byte of each four-byte slot
`define IVL_FIX_UNDEF      24'hFFFFDC
`define IVL_FIX_OVERFLOW   24'hFFFFE0
`define IVL_FIX_BREAK      24'hFFFFE4
`define IVL_FIX_ADDR_MATCH 24'hFFFFE8
`define IVL_FIX_WATCHDOG   24'hFFFFF0
`define IVL_FIX_NMI        24'hFFFFF8
`define IVL_FIX_RESET      24'hFFFFFC

// Top byte value that sends a break to relocatable entry 0
`define IVL_BRK_REDIRECT   8'hFF

// Fixed source selectors
`define IVL_SEL_UNDEF      4'h0
`define IVL_SEL_OVERFLOW   4'h1
`define IVL_SEL_BREAK      4'h2
`define IVL_SEL_ADDR_MATCH 4'h3
`define IVL_SEL_WATCHDOG   4'h4
`define IVL_SEL_OSC_STOP   4'h5
`define IVL_SEL_LOW_VOLT   4'h6
`define IVL_SEL_NMI        4'h7
`define IVL_SEL_RESET      4'h8

// Request kinds
`define IVL_KIND_FIXED     3'h0
`define IVL_KIND_SOFT      3'h1
`define IVL_KIND_DMA       3'h2
`define IVL_KIND_TMR_A     3'h3
`define IVL_KIND_TMR_B     3'h4
`define IVL_KIND_EXT_PIN   3'h5
`define IVL_KIND_SERIAL    3'h6

// Serial events
`define IVL_EV_TX          3'h0
`define IVL_EV_RX          3'h1
`define IVL_EV_NACK        3'h2
`define IVL_EV_ACK         3'h3
`define IVL_EV_START_STOP  3'h4

// Relocatable entry numbers
`define IVL_NUM_BREAK      6'h00
`define IVL_NUM_DMA        6'h08
`define IVL_NUM_TMR_A      6'h0C
`define IVL_NUM_SER0       6'h11
`define IVL_NUM_SER1       6'h13
`define IVL_NUM_TMR_B      6'h15
`define IVL_NUM_EXT_PIN0   6'h1F
`define IVL_NUM_TMR_B5     6'h20
`define IVL_NUM_SER2       6'h21
`define IVL_NUM_SER3       6'h23
`define IVL_NUM_SER4       6'h25

// Channel counts per source group, and the selector of second-group timer five
`define IVL_CNT_DMA        6'h04
`define IVL_CNT_TMR_A      6'h05
`define IVL_CNT_TMR_B      6'h06
`define IVL_CNT_EXT_PIN    6'h06
`define IVL_CNT_SERIAL     6'h05
`define IVL_TMR_B5_SEL     6'h05

// Vector fetch
`define IVL_LAST_BYTE      2'h3
`define IVL_ENTRY_SHIFT    2'h0

`endif

/* sim/ivl_vector_lookup_properties.sv */
/* Checker for the vector lookup ports.
   Assumes one clock domain and an asynchronous active-high reset. */
module ivl_vector_lookup_properties #(parameter ADDR_W = 24) (
  input wire              clk_i,
  input wire              rst_i,
  input wire              ack_valid_i,
  input wire [2:0]        ack_kind_i,
  input wire [5:0]        ack_sel_i,
  input wire              ack_ready_o,
  input wire              ack_reject_o,
  input wire [ADDR_W-1:0] vector_base_register_i,
  input wire              mem_rd_o,
  input wire [ADDR_W-1:0] mem_addr_o,
  input wire              mem_rdy_i,
  input wire [7:0]        mem_data_i,
  input wire              handler_valid_o,
  input wire [ADDR_W-1:0] vector_addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; ack_valid_i && ack_ready_o; endsequence
  sequence s_byte; mem_rd_o && mem_rdy_i; endsequence
  chk_take_answer: assert property (s_take |=> (mem_rd_o && !ack_ready_o) || (ack_reject_o && ack_ready_o))
    else $error("request not answered");
  chk_byte_step: assert property (s_byte and mem_addr_o != 24'hFFFFE7 |=> !mem_rd_o || mem_addr_o == $past(mem_addr_o) + 24'h1)
    else $error("byte address did not step");
  chk_dma_addr: assert property (s_take and ack_kind_i == 3'h2 && ack_sel_i < 6'h4 |=> mem_addr_o == $past(vector_base_register_i) + {$past(ack_sel_i) + 6'h8, 2'h0})
    else $error("dma vector address wrong");
  chk_pin_addr: assert property (s_take and ack_kind_i == 3'h5 && ack_sel_i < 6'h6 |=> mem_addr_o == $past(vector_base_register_i) + {6'h1F - $past(ack_sel_i), 2'h0})
    else $error("pin vector address wrong");
  chk_shared_slot: assert property (s_take and ack_kind_i == 3'h0 && ack_sel_i inside {[6'h4:6'h6]} |=> mem_addr_o == 24'hFFFFF0)
    else $error("shared fixed slot wrong");
  chk_brk_redirect: assert property (s_byte and mem_addr_o == 24'hFFFFE7 && mem_data_i == 8'hFF && vector_addr_o == 24'hFFFFE4 |=> mem_rd_o ##0 mem_addr_o == vector_addr_o)
    else $error("break redirect missing");
  chk_done_ready: assert property (handler_valid_o |=> ack_ready_o && !handler_valid_o)
    else $error("ready not back after result");
  chk_done_idle: assert property (handler_valid_o |-> !mem_rd_o && !ack_ready_o)
    else $error("fetch still active at result");
  chk_reject_idle: assert property (ack_reject_o |-> ack_ready_o && !mem_rd_o)
    else $error("reject left block busy");
endmodule

bind ivl_vector_lookup ivl_vector_lookup_properties #(.ADDR_W(ADDR_W)) chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ack_valid_i(ack_valid_i), .ack_kind_i(ack_kind_i), .ack_sel_i(ack_sel_i),
  .ack_ready_o(ack_ready_o), .ack_reject_o(ack_reject_o), .vector_base_register_i(vector_base_register_i),
  .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_rdy_i(mem_rdy_i), .mem_data_i(mem_data_i),
  .handler_valid_o(handler_valid_o), .vector_addr_o(vector_addr_o));

/* sim/ivl_mem_model.sv */
/* Byte memory answering vector reads with optional stalls.
   Assumes reads are held until each byte is taken. */
module ivl_mem_model (
  input  wire logic        clk_i,
  input  wire logic        stall_i,
  input  wire logic        mem_rd_i,
  input  wire logic [23:0] mem_addr_i,
  input  wire logic [7:0]  brk_top_i,
  output logic             mem_rdy_o,
  output logic [7:0]       mem_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  function automatic [7:0] mb(input [23:0] a);
    mb = (a == 24'hFFFFE7) ? brk_top_i : a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
  endfunction
  initial mem_rdy_o = 1'b0;
  initial mem_data_o = 8'h00;
  // Idle data is inverted so a stale byte is never mistaken for a fresh one
  always @(negedge clk_i) begin
    mem_rdy_o <= mem_rd_i && !(stall_i && $urandom % 2);
    mem_data_o <= mem_rd_i ? mb(mem_addr_i) : ~mem_data_o;
  end
endmodule

/* sim/tb_ivl_vector_lookup.sv */
/* Self-checking bench for the vector lookup with a byte memory model.
   Assumes one 20 MHz clock; inputs change at the falling edge. */
module tb_ivl_vector_lookup;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk_i = 0, rst_i = 1, ack_valid_i = 0, i2c_mode_i = 0, stall = 0;
  reg [2:0] ack_kind_i = 0, ack_event_i = 0;
  reg [5:0] ack_sel_i = 0;
  reg [23:0] base = 0;
  reg [7:0] brk_top = 0;
  wire ack_ready_o, ack_reject_o, mem_rd_o, mem_rdy_i, handler_valid_o;
  wire [23:0] mem_addr_o, vector_addr_o;
  wire [7:0] mem_data_i;
  wire [31:0] handler_addr_o;
  integer n_fail = 0, num_checks = 0, i;
  always #25 clk_i = ~clk_i;
  ivl_vector_lookup ivl_vector_lookup_inst (.clk_i(clk_i), .rst_i(rst_i), .ack_valid_i(ack_valid_i),
    .ack_kind_i(ack_kind_i), .ack_sel_i(ack_sel_i), .ack_event_i(ack_event_i), .i2c_mode_i(i2c_mode_i),
    .ack_ready_o(ack_ready_o), .ack_reject_o(ack_reject_o), .vector_base_register_i(base),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_rdy_i(mem_rdy_i), .mem_data_i(mem_data_i),
    .handler_valid_o(handler_valid_o), .handler_addr_o(handler_addr_o), .vector_addr_o(vector_addr_o));
  ivl_mem_model ivl_mem_model_inst (.clk_i(clk_i), .stall_i(stall), .mem_rd_i(mem_rd_o),
    .mem_addr_i(mem_addr_o), .brk_top_i(brk_top), .mem_rdy_o(mem_rdy_i), .mem_data_o(mem_data_i));
  task give_verdict;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk32(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  function [23:0] ea(input [2:0] k, input [5:0] s, input [2:0] e);
    reg [5:0] n;
    begin
      case (k)
        3'h1: n = s;
        3'h2: n = 8 + s;
        3'h3: n = 12 + s;
        3'h4: n = (s == 5) ? 32 : 21 + s;
        3'h5: n = 31 - s;
        default: n = (s < 2 ? 17 + 2 * s : 29 + 2 * s) + (e == 1 || e > 2);
      endcase
      if (k != 0) ea = base + {n, 2'h0};
      else ea = s < 4 ? 24'hFFFFDC + 4 * s : s < 7 ? 24'hFFFFF0 : s == 7 ? 24'hFFFFF8 : 24'hFFFFFC;
    end
  endfunction
  function bad(input [2:0] k, input [5:0] s, input [2:0] e, input m);
    case (k)
      3'h0: bad = s > 8;
      3'h1: bad = 0;
      3'h2: bad = s > 3;
      3'h3: bad = s > 4;
      3'h4, 3'h5: bad = s > 5;
      3'h6: bad = s > 4 || (m ? e < 2 : e > 1);
      default: bad = 1;
    endcase
  endfunction
  task run(input [2:0] k, input [5:0] s, input [2:0] e, input m);
    reg [23:0] a;
    reg r;
    integer t;
    begin
      a = ea(k, s, e);
      r = bad(k, s, e, m);
      if (k == 0 && s == 2 && brk_top == 8'hFF) a = base;
      @(negedge clk_i);
      {ack_valid_i, ack_kind_i, ack_sel_i, ack_event_i, i2c_mode_i} = {1'b1, k, s, e, m};
      @(negedge clk_i);
      ack_valid_i = 0;
      for (t = 0; t < 300 && handler_valid_o !== 1 && ack_reject_o !== 1; t++) @(negedge clk_i);
      chk32(ack_reject_o, r);
      chk32(handler_valid_o, !r);
      if (!r) begin
        chk32(handler_addr_o, {ivl_mem_model_inst.mb(a + 3), ivl_mem_model_inst.mb(a + 2),
          ivl_mem_model_inst.mb(a + 1), ivl_mem_model_inst.mb(a)});
        chk32(vector_addr_o, a);
      end
    end
  endtask
  initial begin
    #2000000;
    n_fail++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'hADB5AEDC));
    repeat (16) @(negedge clk_i);
    rst_i = 0;
    brk_top = 8'hFF;
    base = 24'h001000;
    for (i = 0; i < 10; i++) run(0, i, 0, 0);
    brk_top = 8'h12;
    run(0, 2, 0, 0);
    for (i = 0; i < 60; i++) run(6, i / 10, i % 5, (i / 5) % 2);
    for (i = 0; i < 28; i++) run(2 + i / 7, i % 7, 0, 0);
    for (i = 0; i < 8; i++) run(1, i, 0, 0);
    run(1, 63, 0, 0);
    run(0, 18, 0, 0);
    run(7, 0, 0, 0);
    base = 24'hFFFFFD;
    run(5, 0, 0, 0);
    for (i = 0; i < 300; i++) begin
      base = $urandom & 24'hFFFFFE;
      stall = $urandom;
      brk_top = $urandom % 2 ? 8'hFF : $urandom;
      run($urandom % 8, $urandom % 10, $urandom % 5, $urandom);
    end
    // Reset in the middle of a fetch, then one more request
    @(negedge clk_i);
    {ack_valid_i, ack_kind_i, ack_sel_i} = {1'b1, 3'h2, 6'h01};
    @(negedge clk_i);
    ack_valid_i = 0;
    @(negedge clk_i);
    rst_i = 1;
    @(negedge clk_i);
    chk32({ack_ready_o, mem_rd_o, handler_valid_o, ack_reject_o}, 4'h8);
    chk32(vector_addr_o, 0);
    chk32(handler_addr_o, 0);
    rst_i = 0;
    run(2, 1, 0, 0);
    give_verdict;
  end
endmodule
